// ### shared/tsd_params.svh
`ifndef TSD_PARAMS_SVH
`define TSD_PARAMS_SVH

// Register indices; byte address is four times the index
`define TSD_IDX_REF_TRIM     12'h07c
`define TSD_IDX_TERM_A       12'h07e
`define TSD_IDX_TERM_B       12'h07f
`define TSD_IDX_TERM_C       12'h080
`define TSD_IDX_TERM_D       12'h081
`define TSD_IDX_OVERLAP      12'h09a

// Field positions and widths
`define TSD_REF_CODE_MSB     3
`define TSD_REF_CODE_W       4
`define TSD_TERM_W           8
`define TSD_DLY_MSB          4
`define TSD_DLY_W            5

// Reset values
`define TSD_RST_REF_TRIM     4'h0
`define TSD_RST_TERM         8'h00
`define TSD_RST_OVERLAP      5'h08

// Overlap timing: base count in converter clock cycles
`define TSD_OVL_BASE         7'h04
`define TSD_OVL_CNT_W        7

`endif

// ### shared/tsd_pkg.sv
package tsd_pkg;

  // Start-up loading of fuse trims
  typedef enum logic [0:0] {
    TSD_LOAD_FUSE,
    TSD_LOAD_DONE
  } tsd_load_e;

  // Core swap overlap sequencer
  typedef enum logic [0:0] {
    TSD_SWAP_IDLE,
    TSD_SWAP_OVERLAP
  } tsd_swap_e;

  // Register selected by an address
  typedef enum logic [2:0] {
    TSD_SEL_NONE,
    TSD_SEL_REF,
    TSD_SEL_TERM_A,
    TSD_SEL_TERM_B,
    TSD_SEL_TERM_C,
    TSD_SEL_TERM_D,
    TSD_SEL_OVERLAP
  } tsd_sel_e;

endpackage : tsd_pkg

// ### src/tsd_trim_and_swap_delay_regs.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsd_params.svh"

module tsd_trim_and_swap_delay_regs
  import tsd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [`TSD_REF_CODE_W-1:0]    fuse_reference_trim,
  input  wire logic [`TSD_TERM_W-1:0]        fuse_termination_a,
  input  wire logic [`TSD_TERM_W-1:0]        fuse_termination_b,
  input  wire logic [`TSD_TERM_W-1:0]        fuse_termination_c,
  input  wire logic [`TSD_TERM_W-1:0]        fuse_termination_d,
  input  wire logic                          cal_enable,
  input  wire logic                          converter_clock_en,
  input  wire logic                          swap_start,
  output logic      [`TSD_REF_CODE_W-1:0]    reference_trim_code,
  output logic      [`TSD_TERM_W-1:0]        termination_trim_a,
  output logic      [`TSD_TERM_W-1:0]        termination_trim_b,
  output logic      [`TSD_TERM_W-1:0]        termination_trim_c,
  output logic      [`TSD_TERM_W-1:0]        termination_trim_d,
  output logic      [`TSD_DLY_W-1:0]         swap_overlap_delay_field,
  output logic                               dual_sampling,
  output logic                               fuse_loaded
);

  // Index 0x09a needs a byte address of 0x268, so ten bits at least
  if (ADDR_W < 10) begin : g_addr_w_check
    $error("tsd_trim_and_swap_delay_regs: ADDR_W must be at least 10");
  end

  // Address decode, shared by read and write paths
  function automatic tsd_sel_e decode_sel(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    if (addr[1:0] != 2'h0) begin
      decode_sel = TSD_SEL_NONE;
    end else if (idx == ADDR_W'(`TSD_IDX_REF_TRIM)) begin
      decode_sel = TSD_SEL_REF;
    end else if (idx == ADDR_W'(`TSD_IDX_TERM_A)) begin
      decode_sel = TSD_SEL_TERM_A;
    end else if (idx == ADDR_W'(`TSD_IDX_TERM_B)) begin
      decode_sel = TSD_SEL_TERM_B;
    end else if (idx == ADDR_W'(`TSD_IDX_TERM_C)) begin
      decode_sel = TSD_SEL_TERM_C;
    end else if (idx == ADDR_W'(`TSD_IDX_TERM_D)) begin
      decode_sel = TSD_SEL_TERM_D;
    end else if (idx == ADDR_W'(`TSD_IDX_OVERLAP)) begin
      decode_sel = TSD_SEL_OVERLAP;
    end else begin
      decode_sel = TSD_SEL_NONE;
    end
  endfunction : decode_sel

  // Bus phase decode
  logic     setup_phase;
  logic     access_wr;
  tsd_sel_e sel;

  assign setup_phase = psel & ~penable;
  assign access_wr   = psel & penable & pwrite & pstrb[0];
  assign sel         = decode_sel(paddr);

  // Zero wait states; the answer is ready as soon as the access phase opens
  assign pready = 1'b1;

  // Register state and next values
  tsd_load_e                  load_state;
  tsd_load_e                  next_load_state;
  logic [`TSD_REF_CODE_W-1:0] next_reference_trim_code;
  logic [`TSD_TERM_W-1:0]     next_termination_trim_a;
  logic [`TSD_TERM_W-1:0]     next_termination_trim_b;
  logic [`TSD_TERM_W-1:0]     next_termination_trim_c;
  logic [`TSD_TERM_W-1:0]     next_termination_trim_d;
  logic [`TSD_DLY_W-1:0]      next_swap_overlap_delay_field;

  // Fuse copy happens once, on the first edge after reset release
  always_comb begin
    next_load_state               = load_state;
    next_reference_trim_code      = reference_trim_code;
    next_termination_trim_a       = termination_trim_a;
    next_termination_trim_b       = termination_trim_b;
    next_termination_trim_c       = termination_trim_c;
    next_termination_trim_d       = termination_trim_d;
    next_swap_overlap_delay_field = swap_overlap_delay_field;
    case (load_state)
      TSD_LOAD_FUSE: begin
        next_reference_trim_code = fuse_reference_trim;
        next_termination_trim_a  = fuse_termination_a;
        next_termination_trim_b  = fuse_termination_b;
        next_termination_trim_c  = fuse_termination_c;
        next_termination_trim_d  = fuse_termination_d;
        next_load_state          = TSD_LOAD_DONE;
      end
      TSD_LOAD_DONE: begin
        if (access_wr) begin
          // Reserved bits are not stored; host keeps them zero anyway
          if (sel == TSD_SEL_REF) begin
            next_reference_trim_code = pwdata[`TSD_REF_CODE_MSB:0];
          end else if (sel == TSD_SEL_TERM_A) begin
            next_termination_trim_a = pwdata[`TSD_TERM_W-1:0];
          end else if (sel == TSD_SEL_TERM_B) begin
            next_termination_trim_b = pwdata[`TSD_TERM_W-1:0];
          end else if (sel == TSD_SEL_TERM_C) begin
            next_termination_trim_c = pwdata[`TSD_TERM_W-1:0];
          end else if (sel == TSD_SEL_TERM_D) begin
            next_termination_trim_d = pwdata[`TSD_TERM_W-1:0];
          end else if (sel == TSD_SEL_OVERLAP) begin
            // Any 0..31 is legal; the sequencer latches it at swap start
            next_swap_overlap_delay_field = pwdata[`TSD_DLY_MSB:0];
          end
        end
      end
      default: begin
        next_load_state = TSD_LOAD_FUSE;
      end
    endcase
  end

  // Register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state               <= TSD_LOAD_FUSE;
      reference_trim_code      <= `TSD_RST_REF_TRIM;
      termination_trim_a       <= `TSD_RST_TERM;
      termination_trim_b       <= `TSD_RST_TERM;
      termination_trim_c       <= `TSD_RST_TERM;
      termination_trim_d       <= `TSD_RST_TERM;
      swap_overlap_delay_field <= `TSD_RST_OVERLAP;
    end else begin
      load_state               <= next_load_state;
      reference_trim_code      <= next_reference_trim_code;
      termination_trim_a       <= next_termination_trim_a;
      termination_trim_b       <= next_termination_trim_b;
      termination_trim_c       <= next_termination_trim_c;
      termination_trim_d       <= next_termination_trim_d;
      swap_overlap_delay_field <= next_swap_overlap_delay_field;
    end
  end

  assign fuse_loaded = (load_state == TSD_LOAD_DONE);

  // Read data is captured in the setup cycle so prdata comes from a flop
  logic [31:0] next_prdata;
  logic        next_pslverr;

  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (sel == TSD_SEL_NONE) begin
        next_pslverr = 1'b1; // Unmapped or misaligned address
      end else if (!pwrite) begin
        if (sel == TSD_SEL_REF) begin
          next_prdata[`TSD_REF_CODE_MSB:0] = reference_trim_code;
        end else if (sel == TSD_SEL_TERM_A) begin
          next_prdata[`TSD_TERM_W-1:0] = termination_trim_a;
        end else if (sel == TSD_SEL_TERM_B) begin
          next_prdata[`TSD_TERM_W-1:0] = termination_trim_b;
        end else if (sel == TSD_SEL_TERM_C) begin
          next_prdata[`TSD_TERM_W-1:0] = termination_trim_c;
        end else if (sel == TSD_SEL_TERM_D) begin
          next_prdata[`TSD_TERM_W-1:0] = termination_trim_d;
        end else if (sel == TSD_SEL_OVERLAP) begin
          next_prdata[`TSD_DLY_MSB:0] = swap_overlap_delay_field;
        end
      end
    end
  end

  // Read path registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Swap overlap sequencer, counting converter clock enables
  tsd_swap_e                 swap_state;
  tsd_swap_e                 next_swap_state;
  logic [`TSD_OVL_CNT_W-1:0] ovl_cnt;
  logic [`TSD_OVL_CNT_W-1:0] next_ovl_cnt;
  logic [`TSD_OVL_CNT_W-1:0] ovl_len;

  // Length 4 + 2*delay, at most 66, fits seven bits
  assign ovl_len = `TSD_OVL_BASE + {1'b0, swap_overlap_delay_field, 1'b0};

  // A swap while overlapping is ignored; the calibration engine owns pacing
  always_comb begin
    next_swap_state = swap_state;
    next_ovl_cnt    = ovl_cnt;
    case (swap_state)
      TSD_SWAP_IDLE: begin
        if (swap_start) begin
          next_swap_state = TSD_SWAP_OVERLAP;
          next_ovl_cnt    = ovl_len;
        end
      end
      TSD_SWAP_OVERLAP: begin
        if (converter_clock_en) begin
          if (ovl_cnt == `TSD_OVL_CNT_W'(1)) begin
            next_swap_state = TSD_SWAP_IDLE;
            next_ovl_cnt    = `TSD_OVL_CNT_W'(0);
          end else begin
            next_ovl_cnt = ovl_cnt - `TSD_OVL_CNT_W'(1);
          end
        end
      end
      default: begin
        next_swap_state = TSD_SWAP_IDLE;
        next_ovl_cnt    = `TSD_OVL_CNT_W'(0);
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_state <= TSD_SWAP_IDLE;
      ovl_cnt    <= `TSD_OVL_CNT_W'(0);
    end else begin
      swap_state <= next_swap_state;
      ovl_cnt    <= next_ovl_cnt;
    end
  end

  // Both cores on the same input while overlapping
  assign dual_sampling = (swap_state == TSD_SWAP_OVERLAP);

  // cal_enable is observed only by the host; kept as a port for the map
  logic unused_ok;
  assign unused_ok = cal_enable & (|pwdata[31:8]) & (|pstrb[3:1]);

endmodule : tsd_trim_and_swap_delay_regs

`default_nettype wire

// ### verif/tsd_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsd_params.svh"

module tsd_regs_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [ADDR_W-1:0]          paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pslverr,
  input wire logic [`TSD_REF_CODE_W-1:0] fuse_reference_trim,
  input wire logic [`TSD_TERM_W-1:0]     fuse_termination_a,
  input wire logic                       converter_clock_en,
  input wire logic                       swap_start,
  input wire logic [`TSD_REF_CODE_W-1:0] reference_trim_code,
  input wire logic [`TSD_TERM_W-1:0]     termination_trim_a,
  input wire logic [`TSD_DLY_W-1:0]      swap_overlap_delay_field,
  input wire logic                       dual_sampling,
  input wire logic                       fuse_loaded
);
  logic [6:0] cnt;
  logic [4:0] dly;
  wire  [6:0] tgt = 7'h04 + {1'b0, dly, 1'b0};

  // Pulses counted during overlap; delay latched at start like the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 7'h00;
      dly <= 5'h00;
    end else if (swap_start && !dual_sampling) begin
      cnt <= 7'h00;
      dly <= swap_overlap_delay_field;
    end else if (dual_sampling && converter_clock_en) begin
      cnt <= cnt + 7'h01;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write access edge; fuse load edge excluded since it wins
  sequence s_wr(a);
    psel && penable && pwrite && pstrb[0] && fuse_loaded && paddr == a;
  endsequence

  AST_REF_WR: assert property (s_wr(12'h1f0) |=> reference_trim_code == $past(pwdata[3:0]))
    else $error("reference trim write not stored");
  AST_TERM_WR: assert property (s_wr(12'h1f8) |=> termination_trim_a == $past(pwdata[7:0]))
    else $error("termination trim write not stored");
  AST_DLY_WR: assert property (s_wr(12'h268) |=> swap_overlap_delay_field == $past(pwdata[4:0]))
    else $error("overlap delay write not stored");
  AST_FUSE: assert property ($rose(fuse_loaded) |-> reference_trim_code == $past(fuse_reference_trim)
    && termination_trim_a == $past(fuse_termination_a)) else $error("fuse trims not loaded");
  AST_RD_DLY: assert property (psel && !penable && !pwrite && paddr == 12'h268
    |=> prdata == {27'h0, swap_overlap_delay_field}) else $error("overlap read wrong");
  AST_UNMAPPED: assert property (psel && !penable && paddr == 12'h1f4 |=> pslverr && prdata == 32'h0)
    else $error("hole access not refused");
  AST_SWAP_GO: assert property (swap_start && !dual_sampling |=> dual_sampling)
    else $error("overlap did not start");
  AST_SWAP_LEN: assert property ($fell(dual_sampling) |-> cnt == tgt)
    else $error("overlap ended at wrong count");
  AST_SWAP_HOLD: assert property (dual_sampling |-> cnt < tgt)
    else $error("overlap ran too long");
endmodule : tsd_regs_sva

`default_nettype wire

// ### verif/tb_trim_and_swap_delay_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_trim_and_swap_delay_regs
  import tsd_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, cal_enable, swap_start;
  logic        conv_en = 1'b0;
  logic        pready, pslverr, er, dual_sampling, fuse_loaded;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, n;
  logic [3:0]  pstrb, ref_code, f_ref;
  logic [7:0]  term_a, term_b, term_c, term_d, f_a, f_b, f_c, f_d;
  logic [4:0]  dly_field;
  int          err_count, check_count, k;
  logic [11:0] addr [6] = '{12'h1f0, 12'h1f8, 12'h1fc, 12'h200, 12'h204, 12'h268};
  logic [31:0] rv [6] = '{32'ha, 32'h5a, 32'ha5, 32'h3c, 32'hc3, 32'h8};
  logic [31:0] wv [6] = '{32'h5, 32'hff, 32'h0, 32'h81, 32'h7e, 32'h1f};
  logic [31:0] fv [6] = '{32'h3, 32'h11, 32'h22, 32'h44, 32'h88, 32'h8};
  logic [4:0]  dl [4] = '{5'h08, 5'h07, 5'h00, 5'h1f};

  tsd_trim_and_swap_delay_regs #(.ADDR_W(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_reference_trim(f_ref), .fuse_termination_a(f_a),
    .fuse_termination_b(f_b), .fuse_termination_c(f_c), .fuse_termination_d(f_d),
    .cal_enable(cal_enable), .converter_clock_en(conv_en), .swap_start(swap_start),
    .reference_trim_code(ref_code), .termination_trim_a(term_a),
    .termination_trim_b(term_b), .termination_trim_c(term_c),
    .termination_trim_d(term_d), .swap_overlap_delay_field(dly_field),
    .dual_sampling(dual_sampling), .fuse_loaded(fuse_loaded));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Converter clock at half the register rate
  always @(posedge pclk) conv_en <= ~conv_en;

  task automatic test_done;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Delay written with calibration idle, then one swap; counts overlap pulses
  task automatic swap(input logic [4:0] d, output logic [31:0] cnt);
    int i;
    logic seen;
    cal_enable <= 1'b0;
    apb(1'b1, 12'h268, {27'h0, d}, 4'h1);
    cnt = 0;
    seen = 1'b0;
    swap_start <= 1'b1;
    cal_enable <= 1'b1;
    @(posedge pclk);
    swap_start <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (dual_sampling === 1'b1) begin
        seen = 1'b1;
        cnt += {31'h0, conv_en};
      end else if (seen) break;
    end
    if (i == 400) begin
      err_count++;
      test_done();
    end
  endtask : swap

  initial begin
    {presetn, psel, penable, pwrite, cal_enable, swap_start} = 6'h0;
    {f_ref, f_a, f_b, f_c, f_d} = {4'ha, 8'h5a, 8'ha5, 8'h3c, 8'hc3};
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_count = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Fuse trims and delay default after reset
    for (k = 0; k < 6; k++) begin
      apb(1'b0, addr[k], 32'h0, 4'h0);
      chk("reset value", rv[k], rd);
    end
    // Boundary values, reserved bits written as zero
    for (k = 0; k < 6; k++) begin
      apb(1'b1, addr[k], wv[k], 4'h1);
      apb(1'b0, addr[k], 32'h0, 4'h0);
      chk("readback", wv[k], rd);
    end
    // Register outputs must follow the stored values
    chk("trim pins", {wv[0][7:0], wv[1][7:0], wv[2][7:0], wv[3][7:0]},
        {4'h0, ref_code, term_a, term_b, term_c});
    chk("delay pins", {15'h0, 1'b1, wv[4][7:0], wv[5][7:0]},
        {15'h0, fuse_loaded, term_d, 3'h0, dly_field});
    // Low strobe write must leave the trim alone
    apb(1'b1, 12'h1f0, 32'h3, 4'h0);
    apb(1'b0, 12'h1f0, 32'h0, 4'h0);
    chk("strobe", wv[0], rd);
    // Hole between the trim registers
    apb(1'b0, 12'h1f4, 32'h0, 4'h0);
    chk("hole error", 32'h1, {31'h0, er});
    chk("hole data", 32'h0, rd);
    // Default, one below default, shortest and longest overlap
    for (k = 0; k < 4; k++) begin
      swap(dl[k], n);
      chk("overlap", 32'h4 + {26'h0, dl[k], 1'b0}, n);
    end
    // Mid-run reset with new fuse contents; trims must follow the fuses
    {f_ref, f_a, f_b, f_c, f_d} <= {4'h3, 8'h11, 8'h22, 8'h44, 8'h88};
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("in reset", 32'h8, {fuse_loaded, ref_code, term_a, term_d, 6'h0, dly_field});
    presetn <= 1'b1;
    for (k = 0; k < 6; k++) begin
      apb(1'b0, addr[k], 32'h0, 4'h0);
      chk("new fuse value", fv[k], rd);
    end
    test_done();
  end
endmodule : tb_trim_and_swap_delay_regs

bind tsd_trim_and_swap_delay_regs tsd_regs_sva #(.ADDR_W(ADDR_W)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr,
  .fuse_reference_trim, .fuse_termination_a, .converter_clock_en, .swap_start,
  .reference_trim_code, .termination_trim_a, .swap_overlap_delay_field, .dual_sampling,
  .fuse_loaded);

`default_nettype wire
